//--- pmc_params.svh
// Offsets, field masks and reset values of the port configuration logic
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

// ==========================================================
// Register offsets within the chip-select I/O space (plus port index)
`define PMC_OFS_CTRL 8'h00
`define PMC_OFS_DIR 8'h04
`define PMC_OFS_DRV 8'h08
`define PMC_RESET_VAL 8'h00
`define PMC_ZERO_BYTE 8'h00
`define PMC_FULL_BYTE 8'hff

// ==========================================================
// Implemented bits and pin capabilities per port
`define PMC_DIR_MASK_D 8'h06
`define PMC_DRV_MASK_C 8'h9c
`define PMC_DRV_MASK_D 8'h06
`define PMC_OD_MASK_AB 8'hf0
`define PMC_OD_MASK_C 8'h9c
`define PMC_SLEW_MASK_AB 8'h0f
`define PMC_SLEW_MASK_D 8'h06
`define PMC_MC2_C_MASK 8'h9c
`define PMC_ECS_D_MASK 8'h06

// ==========================================================
// Peripheral mode enable bit in the memory map configuration
`define PMC_VM_PIO_BIT 7

`endif

//--- pmc_pkg.sv
// Types shared by the port configuration logic
package pmc_pkg;
    typedef logic [7:0] pmc_byte_t;
    typedef logic [31:0] pmc_pins_t;
    typedef enum logic [1:0] {PMC_PORT_A, PMC_PORT_B, PMC_PORT_C, PMC_PORT_D}
        pmc_port_t;
    typedef enum logic [1:0] {PMC_KIND_CTRL, PMC_KIND_DIR, PMC_KIND_DRV,
        PMC_KIND_NONE} pmc_kind_t;
endpackage

//--- pmc_port_cfg.sv
// Pin mode selection and configuration registers for four ports
`timescale 1ns/1ps
`include "pmc_params.svh"

module pmc_port_cfg #(
    parameter logic [31:0] PLD_OUT_MASK = 32'h0000_0000, // Pins fused as logic outputs
    parameter logic PORTB_FROM_TWO = 1'b0 // Port B fed by group two
) (
    input wire logic clk, // 20 MHz processor bus clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic cs_io, // Chip-select I/O space cycle
    input wire pmc_pkg::pmc_byte_t bus_addr, // Offset within the I/O space
    input wire logic bus_wr, // Write cycle strobe
    input wire logic bus_rd, // Read cycle strobe
    input wire pmc_pkg::pmc_byte_t bus_wdata, // Processor write data
    output pmc_pkg::pmc_byte_t bus_rdata, // Register read data
    input wire pmc_pkg::pmc_byte_t memory_map_config, // Memory map config
    input wire logic periph_select_a, // Peripheral select term a
    input wire logic periph_select_b, // Peripheral select term b
    input wire logic program_store_strobe, // Program space cycle
    input wire pmc_pkg::pmc_byte_t addr_latched, // Latched address a7-a0
    input wire pmc_pkg::pmc_pins_t data_out, // Data out register bits
    input wire pmc_pkg::pmc_pins_t pt_oe, // Output enable product terms
    input wire pmc_pkg::pmc_byte_t macrocell_group_one, // Group one outputs
    input wire pmc_pkg::pmc_byte_t macrocell_group_two, // Group two outputs
    input wire logic [1:0] ext_cs, // External chip select terms
    input wire pmc_pkg::pmc_pins_t pin_in, // Pin input levels
    output pmc_pkg::pmc_pins_t pin_out, // Pin output levels
    output pmc_pkg::pmc_pins_t pin_oe, // Pin output enables
    output pmc_pkg::pmc_pins_t pin_fast_slew, // Fast slew selects
    output logic periph_buffer_enable, // Peripheral buffer active
    output pmc_pkg::pmc_byte_t periph_rdata // Port A data toward the bus
);
    import pmc_pkg::*;

    // ==========================================================
    // Decode and capability functions
    function automatic pmc_kind_t reg_kind(input pmc_byte_t a);
        pmc_kind_t k;
        k = PMC_KIND_NONE;
        if (a[7:2] == `PMC_OFS_CTRL >> 2 && a[1] == 1'b0)
            k = PMC_KIND_CTRL;
        else if (a[7:2] == `PMC_OFS_DIR >> 2)
            k = PMC_KIND_DIR;
        else if (a[7:2] == `PMC_OFS_DRV >> 2)
            k = PMC_KIND_DRV;
        return k;
    endfunction

    function automatic pmc_byte_t dir_mask(input pmc_port_t p);
        return (p == PMC_PORT_D) ? `PMC_DIR_MASK_D : `PMC_FULL_BYTE;
    endfunction

    function automatic pmc_byte_t drv_mask(input pmc_port_t p);
        pmc_byte_t m;
        m = `PMC_FULL_BYTE;
        if (p == PMC_PORT_C)
            m = `PMC_DRV_MASK_C;
        else if (p == PMC_PORT_D)
            m = `PMC_DRV_MASK_D;
        return m;
    endfunction

    function automatic pmc_byte_t od_mask(input pmc_port_t p);
        pmc_byte_t m;
        m = `PMC_ZERO_BYTE;
        if (p == PMC_PORT_A || p == PMC_PORT_B)
            m = `PMC_OD_MASK_AB;
        else if (p == PMC_PORT_C)
            m = `PMC_OD_MASK_C;
        return m;
    endfunction

    function automatic pmc_byte_t slew_mask(input pmc_port_t p);
        pmc_byte_t m;
        m = `PMC_ZERO_BYTE;
        if (p == PMC_PORT_A || p == PMC_PORT_B)
            m = `PMC_SLEW_MASK_AB;
        else if (p == PMC_PORT_D)
            m = `PMC_SLEW_MASK_D;
        return m;
    endfunction

    // ==========================================================
    // Configuration registers
    logic [1:0][7:0] ctrl_reg, ctrl_next;
    logic [3:0][7:0] dir_reg, dir_next;
    logic [3:0][7:0] drv_reg, drv_next;
    pmc_byte_t rdata_reg, rdata_next;
    pmc_kind_t acc_kind;
    pmc_port_t acc_port;

    assign acc_kind = reg_kind(bus_addr);
    assign acc_port = pmc_port_t'(bus_addr[1:0]);

    always_comb
    begin
        ctrl_next = ctrl_reg;
        dir_next = dir_reg;
        drv_next = drv_reg;
        rdata_next = rdata_reg;
        if (cs_io && bus_wr)
        begin
            unique case (acc_kind)
                PMC_KIND_CTRL: ctrl_next[acc_port[0]] = bus_wdata;
                PMC_KIND_DIR: dir_next[acc_port] = bus_wdata & dir_mask(acc_port);
                PMC_KIND_DRV: drv_next[acc_port] = bus_wdata & drv_mask(acc_port);
                PMC_KIND_NONE: ;
            endcase
        end
        if (cs_io && bus_rd)
        begin
            unique case (acc_kind)
                PMC_KIND_CTRL: rdata_next = ctrl_reg[acc_port[0]];
                PMC_KIND_DIR: rdata_next = dir_reg[acc_port];
                PMC_KIND_DRV: rdata_next = drv_reg[acc_port];
                PMC_KIND_NONE: rdata_next = `PMC_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctrl_reg <= {2{`PMC_RESET_VAL}};
            dir_reg <= {4{`PMC_RESET_VAL}};
            drv_reg <= {4{`PMC_RESET_VAL}};
            rdata_reg <= `PMC_RESET_VAL;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            dir_reg <= dir_next;
            drv_reg <= drv_next;
            rdata_reg <= rdata_next;
        end
    end

    assign bus_rdata = rdata_reg;

    // ==========================================================
    // Pin input synchroniser
    pmc_pins_t pin_meta_reg, pin_sync_reg;
    pmc_byte_t prd_reg, prd_next;

    assign prd_next = pin_sync_reg[7:0];

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            prd_reg <= `PMC_ZERO_BYTE;
        end
        else
        begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            prd_reg <= prd_next;
        end
    end

    assign periph_rdata = prd_reg;

    // ==========================================================
    // Pin output multiplexer and driver control
    pmc_pins_t pld_src, pld_use;
    pmc_pins_t out_reg, out_next, oe_reg, oe_next, slew_reg, slew_next;
    logic pio_mode, pbe_reg, pbe_next;

    assign pld_src = {{5'h00, ext_cs, 1'b0},
                      macrocell_group_two,
                      PORTB_FROM_TWO ? macrocell_group_two : macrocell_group_one,
                      macrocell_group_one};
    assign pld_use = PLD_OUT_MASK & {`PMC_ECS_D_MASK, `PMC_MC2_C_MASK,
                                     `PMC_FULL_BYTE, `PMC_FULL_BYTE};
    assign pio_mode = memory_map_config[`PMC_VM_PIO_BIT];
    assign pbe_next = pio_mode && (periph_select_a || periph_select_b)
                      && program_store_strobe;

    always_comb
    begin
        out_next = '0;
        oe_next = '0;
        slew_next = '0;
        for (int p = 0; p < 4; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                logic src;
                logic en;
                logic ctl;
                pmc_byte_t odm;
                pmc_byte_t swm;
                src = data_out[p * 8 + b];
                odm = od_mask(pmc_port_t'(p));
                swm = slew_mask(pmc_port_t'(p));
                en = dir_reg[p][b] | pt_oe[p * 8 + b];
                ctl = (p < 2) ? ctrl_reg[p % 2][b] : 1'b0;
                if (pld_use[p * 8 + b])
                    src = pld_src[p * 8 + b];
                else if (ctl)
                    src = addr_latched[b];
                if (drv_reg[p][b] & odm[b])
                begin
                    out_next[p * 8 + b] = 1'b0;
                    oe_next[p * 8 + b] = en & ~src;
                end
                else
                begin
                    out_next[p * 8 + b] = src;
                    oe_next[p * 8 + b] = en;
                end
                slew_next[p * 8 + b] = drv_reg[p][b] & swm[b];
            end
        end
        if (pio_mode)
        begin
            out_next[7:0] = bus_wdata;
            oe_next[7:0] = {8{pbe_next & bus_wr}};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            out_reg <= '0;
            oe_reg <= '0;
            slew_reg <= '0;
            pbe_reg <= 1'b0;
        end
        else
        begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            slew_reg <= slew_next;
            pbe_reg <= pbe_next;
        end
    end

    assign pin_out = out_reg;
    assign pin_oe = oe_reg;
    assign pin_fast_slew = slew_reg;
    assign periph_buffer_enable = pbe_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_dir_a_write;
        cs_io && bus_wr && bus_addr == `PMC_OFS_DIR;
    endsequence

    sequence s_dir_a_read;
        cs_io && bus_rd && !bus_wr && bus_addr == `PMC_OFS_DIR;
    endsequence

    AST_RESET_CLEAR: assert property (@(posedge clk) disable iff (1'b0)
        !rstn |=> dir_reg == '0 && ctrl_reg == '0 && drv_reg == '0)
        else $error("config registers not cleared by reset");
    AST_READBACK: assert property (s_dir_a_write
        ##1 !(cs_io && bus_wr) ##1 s_dir_a_read
        |=> bus_rdata == $past(bus_wdata, 3))
        else $error("direction read back differs from write");
    AST_DIR_OE: assert property (!PLD_OUT_MASK[16] && $past(rstn)
        |-> pin_oe[16] == ($past(dir_reg[2][0]) | $past(pt_oe[16])))
        else $error("port C pin 0 enable not direction or term");
    AST_DATA_OUT: assert property (!PLD_OUT_MASK[16] && $past(rstn)
        && pin_oe[16] |-> pin_out[16] == $past(data_out[16]))
        else $error("data out not on enabled pin");
    AST_ADDR_HIGH: assert property (!PLD_OUT_MASK[13] && ctrl_reg[1][5]
        && !drv_reg[1][5] && dir_reg[1][5]
        |=> pin_out[13] == $past(addr_latched[5]) && pin_oe[13])
        else $error("port B pin 5 not driving address a5");
    AST_ADDR_LOW: assert property (!PLD_OUT_MASK[2] && !pio_mode
        && ctrl_reg[0][2] |=> pin_out[2] == $past(addr_latched[2]))
        else $error("port A pin 2 not carrying address a2");
    AST_PERIPH_TRI: assert property (pio_mode
        && !periph_select_a && !periph_select_b
        |=> pin_oe[7:0] == 8'h00 && !periph_buffer_enable)
        else $error("peripheral buffer driven without select");
    AST_PERIPH_PROGRAM_STORE_STROBE: assert property (pio_mode && !program_store_strobe
        |=> !periph_buffer_enable)
        else $error("peripheral buffer enabled in data space");
    AST_PERIPH_DRIVE: assert property (pbe_next && bus_wr
        |=> pin_oe[7:0] == 8'hff && pin_out[7:0] == $past(bus_wdata))
        else $error("port A not driving processor data");
    AST_OPEN_DRAIN: assert property (!PLD_OUT_MASK[6] && !pio_mode
        && !ctrl_reg[0][6] && drv_reg[0][6] && data_out[6]
        |=> !pin_out[6] && !pin_oe[6])
        else $error("open drain pin driven high");
    AST_SLEW: assert property ($past(rstn)
        |-> pin_fast_slew[3] == $past(drv_reg[0][3]) && !pin_fast_slew[16])
        else $error("slew select does not follow drive bit");
    AST_DIR_D_BITS: assert property (dir_reg[3][0] == 1'b0
        && dir_reg[3][7:3] == 5'h00)
        else $error("unimplemented port D direction bit set");
endmodule

//--- pmc_pin_model.sv
// Model of the peripherals and pull-ups that sit on the port pins
`timescale 1ns/1ps

module pmc_pin_model (
    input wire pmc_pkg::pmc_pins_t pin_out, // Levels from the block
    input wire pmc_pkg::pmc_pins_t pin_oe, // Enables from the block
    input wire pmc_pkg::pmc_byte_t ext_val, // Peripheral data on port A
    input wire logic ext_en, // Peripheral drives port A
    output pmc_pkg::pmc_pins_t pin_in // Resolved pin levels
);
    import pmc_pkg::*;

    // ==========================================================
    // Pin resolution
    always_comb
    begin
        for (int i = 0; i < 32; i++)
        begin
            // peripheral drives only a released bus
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en && i < 8)
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule

//--- pmc_port_cfg_bench.sv
// Self-checking bench for the port configuration logic
`timescale 1ns/1ps

`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end

module pmc_port_cfg_bench;
    import pmc_pkg::*;
    logic clk = 1'b0;
    logic rstn, cs_io, bus_wr, bus_rd, sel_a, sel_b, pss, ext_en;
    pmc_byte_t bus_addr, bus_wdata, bus_rdata, vm, addr_lat, prdata;
    pmc_byte_t ext_val, rd;
    pmc_pins_t data_out, pt_oe, pin_in, pin_out, pin_oe, fast;
    logic pbe;
    pmc_byte_t mc2;
    logic [1:0] ecs;
    int bad_count = 0;
    int n_compared = 0;
    pmc_byte_t ofs_tab [12] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
    // Unmapped offsets and unimplemented bits read back as zero
    pmc_byte_t exp_tab [12] = '{8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff,
        8'h06, 8'hff, 8'hff, 8'h9c, 8'h06, 8'h00};

    always #25 clk = ~clk;

    // Port C pin 7 and port D pin 1 are fused as logic outputs
    pmc_port_cfg #(.PLD_OUT_MASK(32'h0280_0000)) dut_u (.clk(clk),
        .rstn(rstn), .cs_io(cs_io),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .memory_map_config(vm), .periph_select_a(sel_a),
        .periph_select_b(sel_b), .program_store_strobe(pss),
        .addr_latched(addr_lat), .data_out(data_out), .pt_oe(pt_oe),
        .macrocell_group_one(8'h00), .macrocell_group_two(mc2),
        .ext_cs(ecs), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_fast_slew(fast),
        .periph_buffer_enable(pbe), .periph_rdata(prdata));

    pmc_pin_model far_u (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    // ==========================================================
    // Bus and timing tasks
    task automatic reg_write(input pmc_byte_t ofs, input pmc_byte_t val);
        @(posedge clk);
        cs_io <= 1'b1;
        bus_wr <= 1'b1;
        bus_addr <= ofs;
        bus_wdata <= val;
        @(posedge clk);
        cs_io <= 1'b0;
        bus_wr <= 1'b0;
    endtask

    task automatic reg_read(input pmc_byte_t ofs, output pmc_byte_t val);
        @(posedge clk);
        cs_io <= 1'b1;
        bus_rd <= 1'b1;
        bus_addr <= ofs;
        @(posedge clk);
        cs_io <= 1'b0;
        bus_rd <= 1'b0;
        @(posedge clk);
        #1;
        val = bus_rdata;
    endtask

    // Pin outputs trail a register update by one clock
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic tally_and_finish;
        $display("Compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Watchdog
    initial
    begin
        #4000000;
        bad_count++;
        $display("Error watchdog expected finish seen hang");
        tally_and_finish();
    end

    // ==========================================================
    // Main sequence
    initial
    begin
        {rstn, cs_io, bus_wr, bus_rd, sel_a, sel_b, pss, ext_en} <= 8'h00;
        {bus_addr, bus_wdata, vm, ext_val} <= 32'h0;
        {mc2, ecs} <= 10'h200;
        addr_lat <= 8'ha5;
        data_out <= 32'h5a5a_5a5a;
        pt_oe <= 32'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 12; i++)
        begin
            reg_read(ofs_tab[i], rd);
            `CHK("reset value", 8'h00, rd)
        end
        settle();
        `CHK("pin_oe after reset", 32'h0, pin_oe)
        for (int i = 0; i < 12; i++)
        begin
            reg_write(ofs_tab[i], 8'hff);
            reg_read(ofs_tab[i], rd);
            `CHK("readback", exp_tab[i], rd)
            reg_write(ofs_tab[i], 8'h00);
        end
        reg_write(8'h04, 8'h07);
        reg_write(8'h06, 8'h80);
        settle();
        `CHK("dir a oe", 8'h07, pin_oe[7:0])
        `CHK("dir a out", 3'b010, pin_out[2:0])
        `CHK("dir c oe", 8'h80, pin_oe[23:16])
        @(posedge clk);
        pt_oe <= 32'h0001_0000;
        settle();
        `CHK("term oe", 8'h81, pin_oe[23:16])
        `CHK("group two on port c pin 7", 1'b1, pin_out[23])
        `CHK("chip select on port d pin 1", 1'b0, pin_out[25])
        reg_write(8'h04, 8'hff);
        reg_write(8'h08, 8'hff);
        reg_write(8'h0a, 8'hff);
        reg_write(8'h0b, 8'hff);
        settle();
        `CHK("open drain out", 8'h0a, pin_out[7:0])
        `CHK("open drain oe", 8'haf, pin_oe[7:0])
        `CHK("slew a", 8'h0f, fast[7:0])
        `CHK("slew c", 8'h00, fast[23:16])
        `CHK("slew d", 8'h06, fast[31:24])
        reg_write(8'h08, 8'h00);
        reg_write(8'h00, 8'hff);
        reg_write(8'h01, 8'hff);
        settle();
        `CHK("addr a out", 8'ha5, pin_out[7:0])
        `CHK("addr b without enable", 8'h00, pin_oe[15:8])
        @(posedge clk);
        pt_oe <= 32'h0000_ff00;
        settle();
        `CHK("addr b oe", 8'hff, pin_oe[15:8])
        `CHK("addr b out", 8'ha5, pin_out[15:8])
        reg_write(8'h05, 8'hff);
        @(posedge clk);
        pt_oe <= 32'h0;
        settle();
        `CHK("addr b by direction", 8'hff, pin_oe[15:8])
        reg_write(8'h00, 8'h00);
        settle();
        `CHK("processor io again", 8'h5a, pin_out[7:0])
        reg_write(8'h04, 8'h00);
        for (int k = 0; k < 16; k++)
        begin
            @(posedge clk);
            vm <= {k[3], 7'h00};
            {sel_a, sel_b, pss} <= k[2:0];
            settle();
            `CHK("buffer enable", k[3] & (k[2] | k[1]) & k[0], pbe)
        end
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_wdata <= 8'h3c;
        settle();
        `CHK("periph write out", 8'h3c, pin_out[7:0])
        `CHK("periph write oe", 8'hff, pin_oe[7:0])
        @(posedge clk);
        {sel_a, sel_b} <= 2'b00;
        settle();
        `CHK("periph deselected", 8'h00, pin_oe[7:0])
        @(posedge clk);
        {sel_a, bus_wr, ext_en} <= 3'b101;
        ext_val <= 8'hc3;
        repeat (5) @(posedge clk);
        #1;
        `CHK("periph read", 8'hc3, prdata)
        tally_and_finish();
    end
endmodule
